// >>> common/sarseq_pkg.sv
package sarseq_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int INSTR_CYCLE_NS = 80;
   localparam int INSTR_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] INSTR_DLY = 3'(INSTR_CYCLES);
   localparam logic [4:0] CONV_TICKS = 5'h0C;
   localparam logic [4:0] WAIT_TICKS = 5'h02;
   localparam logic [4:0] SAR_BITS = 5'h0A;
   localparam logic [9:0] SAR_FIRST = 10'h200;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PINREF = 8'h04;
   localparam logic [7:0] ADDR_TIMING = 8'h08;
   localparam logic [7:0] ADDR_RES_HI = 8'h0C;
   localparam logic [7:0] ADDR_RES_LO = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   // field positions
   localparam int ON_BIT = 0;
   localparam int GO_BIT = 1;
   localparam int CHS_LSB = 2;
   localparam int REF_LSB = 4;
   localparam int PCFG_LSB = 0;
   localparam int ADCS_LSB = 0;
   localparam int ACQT_LSB = 3;
   localparam int JUST_BIT = 7;
   localparam int FLAG_BIT = 0;
   localparam int BUSY_BIT = 1;
   localparam int SAMP_BIT = 2;
   // values after reset
   localparam logic [3:0] CHS_RST = 4'h0;
   localparam logic [1:0] REF_RST = 2'h0;
   localparam logic [3:0] PCFG_RST = 4'h0;
   localparam logic [2:0] ACQT_RST = 3'h0;
   localparam logic [2:0] ADCS_RST = 3'h0;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACQ = 2'b01,
      ST_CONV = 2'b11,
      ST_WAIT = 2'b10
   } sarseq_state_t;

   function automatic logic [4:0] acq_ticks(input logic [2:0] code);
      logic [4:0] t;
      t = 5'h00;
      unique case (code)
         3'h0: t = 5'h00;
         3'h1: t = 5'h02;
         3'h2: t = 5'h04;
         3'h3: t = 5'h06;
         3'h4: t = 5'h08;
         3'h5: t = 5'h0C;
         3'h6: t = 5'h10;
         3'h7: t = 5'h14;
      endcase
      return t;
   endfunction

   // cycles of mclk per conversion clock period for the divided sources
   function automatic logic [6:0] div_len(input logic [2:0] code);
      logic [6:0] n;
      n = 7'h02;
      unique case (code)
         3'h0: n = 7'h02;
         3'h4: n = 7'h04;
         3'h1: n = 7'h08;
         3'h5: n = 7'h10;
         3'h2: n = 7'h20;
         3'h6: n = 7'h40;
         default: n = 7'h02;
      endcase
      return n;
   endfunction

   function automatic logic is_rc(input logic [2:0] code);
      return code[1:0] == 2'h3;
   endfunction
endpackage

// >>> common/sarseq_clk_if.sv
interface sarseq_clk_if;
   logic run;
   logic [2:0] sel;
   logic sleep;
   logic tick;
   modport ctl (output run, output sel, output sleep, input tick);
   modport gen (input run, input sel, input sleep, output tick);
endinterface

// >>> rtl/sarseq_clkgen.sv
module sarseq_clkgen import sarseq_pkg::*; (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // internal rc oscillator
   input wire logic rc_clk_i,
   // tick carrier
   sarseq_clk_if.gen clk_if
);
   logic [2:0] rc_s_ff;
   logic rc_lvl_ff;
   logic [6:0] div_ff;
   logic [2:0] dly_ff;
   logic div_end;
   logic rc_edge;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rc_s_ff <= 3'h0;
         rc_lvl_ff <= 1'b0;
      end else begin
         rc_s_ff <= {rc_s_ff[1:0], rc_clk_i};
         if (rc_s_ff[1] == rc_s_ff[2]) begin
            rc_lvl_ff <= rc_s_ff[2];
         end
      end
   end

   assign rc_edge = (rc_s_ff[1] == rc_s_ff[2]) && rc_s_ff[2] && !rc_lvl_ff;
   assign div_end = div_ff == 7'(div_len(clk_if.sel) - 7'h01);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || !clk_if.run || div_end) begin
         div_ff <= 7'h00;
      end else begin
         div_ff <= div_ff + 7'h01;
      end
   end

   // start delay before the rc clock runs
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || !clk_if.run) begin
         dly_ff <= INSTR_DLY;
      end else if (dly_ff != 3'h0) begin
         dly_ff <= dly_ff - 3'h1; // see [RULE_09]
      end
   end

   // divided source stops in sleep, rc source keeps running
   assign clk_if.tick = clk_if.run && (is_rc(clk_if.sel) ? (rc_edge && dly_ff == 3'h0) // see [RULE_09]
                                                         : (div_end && !clk_if.sleep)); // see [RULE_08] [RULE_10]

   a_rc_start_delay: // see [RULE_09]
      assert property ($rose(clk_if.run) && is_rc(clk_if.sel) |-> !clk_if.tick [*4])
      else $error("rc conversion clock ran before start delay");
   a_div_sleep_stop: // see [RULE_10]
      assert property (clk_if.sleep && !is_rc(clk_if.sel) |-> !clk_if.tick)
      else $error("divided conversion clock ticked in sleep");
endmodule // sarseq_clkgen

// >>> rtl/sarseq_top.sv
// What this block does
// [RULE_01] 4-bit input_select picks one of sixteen analog inputs, code 0 to 15.
// [RULE_02] writing one to start bit launches conversion; hardware clears it when done.
// [RULE_03] converter_on bit 0 powers converter; start bit only works while on.
// [RULE_04] 2-bit reference_select chooses supplies or external references.
// [RULE_05] 4-bit pin_analog_config sets analog pins; code 0000 makes all analog.
// [RULE_06] result_justify bit 7: one right justified, zero left justified.
// [RULE_07] acquire_delay_select gives 0,2,4,6,8,12,16,20 clock periods.
// [RULE_08] conversion_clock_select divides system clock or picks internal rc clock.
// [RULE_09] rc clock source waits one instruction cycle before it starts.
// [RULE_10] conversions finish during sleep when the rc clock is selected.
// [RULE_11] reset returns control registers to defaults, turns off, aborts conversion.
// [RULE_12] completion loads result, clears start bit and sets done flag together.
// [RULE_13] result pair is never reset; undefined after power-on.
// [RULE_14] nonzero acquisition code samples for that many periods, then converts.
// [RULE_15] at least two periods pass after a conversion before next acquisition.
// [RULE_16] without auto acquisition software waits acquisition time before start.
// [RULE_17] sampling switch opens at conversion start and stays open.
// [RULE_18] successive approximation resolves one result bit per clock period.
// [RULE_19] unused register bits read as zero.
// [RULE_20] software configures, enables, clears flag, starts, waits, reads result.
// [RULE_21] a full conversion takes twelve conversion clock periods.
// [RULE_22] clearing start bit aborts; result keeps last completed or written value.
// [RULE_23] acquisition code 000 converts at once and is the reset default.
// [RULE_24] right justify fills low ten bits, left justify fills top ten bits.
// [RULE_25] after the wait the selected channel is sampled again automatically.
//
// The APB register port and the register offsets were left to the implementer.
module sarseq_top import sarseq_pkg::*; (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // power state and rc oscillator
   input wire logic sleep_i,
   input wire logic rc_clk_i,
   // analog front end
   output logic converter_on_o,
   output logic [3:0] input_select_o,
   output logic [1:0] reference_select_o,
   output logic [15:0] pin_analog_config_o,
   output logic sample_o,
   output logic [9:0] trial_code_o,
   input wire logic cmp_i,
   // status
   output logic conversion_done_flag_o,
   output logic busy_o
);
   sarseq_clk_if clk_if ();

   sarseq_state_t st_ff;
   logic [4:0] cnt_ff;
   logic on_ff;
   logic go_ff;
   logic [3:0] chs_ff;
   logic [1:0] ref_ff;
   logic [3:0] pcfg_ff;
   logic [15:0] pin_mask_ff;
   logic just_ff;
   logic [2:0] acqt_ff;
   logic [2:0] adcs_ff;
   logic flag_ff;
   logic [15:0] result_ff;
   logic [9:0] sar_ff;
   logic [9:0] nxt_sar;
   logic [2:0] cmp_s_ff;
   logic cmp_ok_ff;
   logic [31:0] rd_ff;
   logic [31:0] nxt_rd;
   logic err_ff;
   logic nxt_err;
   logic setup;
   logic wr;
   logic tick;
   logic done;
   logic [4:0] acq_len;
   logic [9:0] bit_mask;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
      return a == reg_addr;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return hit(a, ADDR_CTRL) || hit(a, ADDR_PINREF) || hit(a, ADDR_TIMING)
          || hit(a, ADDR_RES_HI) || hit(a, ADDR_RES_LO) || hit(a, ADDR_STATUS);
   endfunction

   // apb: zero wait states, read data captured in the setup cycle
   assign setup = psel_i && !penable_i;
   assign wr = psel_i && penable_i && pwrite_i && mapped(paddr_i);
   assign pready_o = 1'b1;
   assign prdata_o = rd_ff;
   assign pslverr_o = err_ff;

   always_comb begin
      nxt_rd = 32'h0000_0000;
      nxt_err = !mapped(paddr_i);
      unique case (1'b1)
         hit(paddr_i, ADDR_CTRL): begin
            nxt_rd[CHS_LSB +: 4] = chs_ff; // see [RULE_19]
            nxt_rd[GO_BIT] = go_ff; // see [RULE_02]
            nxt_rd[ON_BIT] = on_ff;
         end
         hit(paddr_i, ADDR_PINREF): begin
            nxt_rd[REF_LSB +: 2] = ref_ff; // see [RULE_19]
            nxt_rd[PCFG_LSB +: 4] = pcfg_ff;
         end
         hit(paddr_i, ADDR_TIMING): begin
            nxt_rd[JUST_BIT] = just_ff; // see [RULE_19]
            nxt_rd[ACQT_LSB +: 3] = acqt_ff;
            nxt_rd[ADCS_LSB +: 3] = adcs_ff;
         end
         hit(paddr_i, ADDR_RES_HI): nxt_rd[7:0] = result_ff[15:8];
         hit(paddr_i, ADDR_RES_LO): nxt_rd[7:0] = result_ff[7:0];
         hit(paddr_i, ADDR_STATUS): begin
            nxt_rd[FLAG_BIT] = flag_ff;
            nxt_rd[BUSY_BIT] = go_ff;
            nxt_rd[SAMP_BIT] = sample_o;
         end
         default: nxt_rd = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rd_ff <= 32'h0000_0000;
         err_ff <= 1'b0;
      end else if (setup) begin
         rd_ff <= nxt_rd;
         err_ff <= nxt_err;
      end
   end

   // control and channel register
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         on_ff <= 1'b0; // see [RULE_11]
         chs_ff <= CHS_RST;
      end else if (wr && hit(paddr_i, ADDR_CTRL)) begin
         on_ff <= pwdata_i[ON_BIT]; // see [RULE_03]
         chs_ff <= pwdata_i[CHS_LSB +: 4]; // see [RULE_01]
      end
   end

   // start bit: set only on an already enabled converter, completion clears it
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         go_ff <= 1'b0; // see [RULE_11]
      end else if (done) begin
         go_ff <= 1'b0; // see [RULE_12]
      end else if (wr && hit(paddr_i, ADDR_CTRL)) begin
         go_ff <= pwdata_i[GO_BIT] && pwdata_i[ON_BIT] && on_ff; // see [RULE_02] [RULE_03]
      end
   end

   // pin and reference register
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ref_ff <= REF_RST;
         pcfg_ff <= PCFG_RST;
         pin_mask_ff <= 16'hFFFF;
      end else if (wr && hit(paddr_i, ADDR_PINREF)) begin
         ref_ff <= pwdata_i[REF_LSB +: 2]; // see [RULE_04]
         pcfg_ff <= pwdata_i[PCFG_LSB +: 4];
         pin_mask_ff <= 16'hFFFF >> pwdata_i[PCFG_LSB +: 4]; // see [RULE_05]
      end
   end

   // timing and format register
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         just_ff <= 1'b0;
         acqt_ff <= ACQT_RST; // see [RULE_23]
         adcs_ff <= ADCS_RST;
      end else if (wr && hit(paddr_i, ADDR_TIMING)) begin
         just_ff <= pwdata_i[JUST_BIT]; // see [RULE_06]
         acqt_ff <= pwdata_i[ACQT_LSB +: 3]; // see [RULE_07]
         adcs_ff <= pwdata_i[ADCS_LSB +: 3]; // see [RULE_08]
      end
   end

   // done flag, write one to clear, a new completion wins
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         flag_ff <= 1'b0;
      end else if (done) begin
         flag_ff <= 1'b1; // see [RULE_12]
      end else if (wr && hit(paddr_i, ADDR_STATUS) && pwdata_i[FLAG_BIT]) begin
         flag_ff <= 1'b0;
      end
   end

   // result pair has no reset so software writes and old results survive
   always_ff @(posedge mclk_i) begin
      if (done) begin
         result_ff <= just_ff ? {6'h00, sar_ff} : {sar_ff, 6'h00}; // see [RULE_12] [RULE_24]
      end else begin
         if (wr && hit(paddr_i, ADDR_RES_HI)) begin
            result_ff[15:8] <= pwdata_i[7:0]; // see [RULE_13] [RULE_22]
         end
         if (wr && hit(paddr_i, ADDR_RES_LO)) begin
            result_ff[7:0] <= pwdata_i[7:0];
         end
      end
   end

   // comparator crossing
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cmp_s_ff <= 3'h0;
         cmp_ok_ff <= 1'b0;
      end else begin
         cmp_s_ff <= {cmp_s_ff[1:0], cmp_i};
         if (cmp_s_ff[1] == cmp_s_ff[2]) begin
            cmp_ok_ff <= cmp_s_ff[2];
         end
      end
   end

   // conversion clock
   assign clk_if.run = on_ff && st_ff != ST_IDLE;
   assign clk_if.sel = adcs_ff;
   assign clk_if.sleep = sleep_i;
   assign tick = clk_if.tick;

   sarseq_clkgen u_clkgen (
      .mclk_i (mclk_i),
      .rst_n_i (rst_n_i),
      .rc_clk_i (rc_clk_i),
      .clk_if (clk_if.gen)
   );

   assign acq_len = acq_ticks(acqt_ff);
   assign done = on_ff && go_ff && st_ff == ST_CONV && tick && cnt_ff == CONV_TICKS - 5'h01;

   // sequencer
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || !on_ff) begin
         st_ff <= ST_IDLE; // see [RULE_11]
         cnt_ff <= 5'h00;
      end else begin
         unique case (st_ff)
            ST_IDLE: begin
               cnt_ff <= 5'h00;
               if (go_ff) begin
                  st_ff <= (acq_len == 5'h00) ? ST_CONV : ST_ACQ; // see [RULE_14] [RULE_23]
               end
            end
            ST_ACQ: begin
               if (!go_ff) begin
                  st_ff <= ST_WAIT; // see [RULE_22]
                  cnt_ff <= 5'h00;
               end else if (tick) begin
                  if (5'(cnt_ff + 5'h01) >= acq_len) begin
                     st_ff <= ST_CONV; // see [RULE_14]
                     cnt_ff <= 5'h00;
                  end else begin
                     cnt_ff <= cnt_ff + 5'h01;
                  end
               end
            end
            ST_CONV: begin
               if (!go_ff || done) begin
                  st_ff <= ST_WAIT; // see [RULE_22] [RULE_15]
                  cnt_ff <= 5'h00;
               end else if (tick) begin
                  cnt_ff <= cnt_ff + 5'h01; // see [RULE_21]
               end
            end
            ST_WAIT: begin
               if (tick) begin
                  if (cnt_ff == WAIT_TICKS - 5'h01) begin
                     st_ff <= ST_IDLE; // see [RULE_15] [RULE_25]
                     cnt_ff <= 5'h00;
                  end else begin
                     cnt_ff <= cnt_ff + 5'h01;
                  end
               end
            end
         endcase
      end
   end

   // first tick sets the msb trial, then one bit decided per tick
   assign bit_mask = SAR_FIRST >> 5'(cnt_ff - 5'h01);

   always_comb begin
      nxt_sar = sar_ff;
      if (cnt_ff == 5'h00) begin
         nxt_sar = SAR_FIRST;
      end else if (cnt_ff <= SAR_BITS) begin
         nxt_sar = (sar_ff & ~bit_mask) | (cmp_ok_ff ? bit_mask : 10'h000) | (bit_mask >> 1); // see [RULE_18]
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sar_ff <= 10'h000;
      end else if (st_ff == ST_CONV && tick) begin
         sar_ff <= nxt_sar; // see [RULE_18]
      end
   end

   // analog side
   assign converter_on_o = on_ff; // see [RULE_03]
   assign input_select_o = chs_ff; // see [RULE_01]
   assign reference_select_o = ref_ff; // see [RULE_04]
   assign pin_analog_config_o = pin_mask_ff; // see [RULE_05]
   assign sample_o = on_ff && (st_ff == ST_IDLE || st_ff == ST_ACQ); // see [RULE_17] [RULE_25]
   assign trial_code_o = sar_ff;
   assign conversion_done_flag_o = flag_ff;
   assign busy_o = go_ff;

   a_go_needs_on: // see [RULE_03]
      assert property (go_ff |-> on_ff)
      else $error("start bit set while converter off");
   a_done_event: // see [RULE_12]
      assert property (done |=> !go_ff && flag_ff && st_ff == ST_WAIT)
      else $error("completion did not clear start and set flag together");
   a_conv_length: // see [RULE_21]
      assert property (done |-> cnt_ff == CONV_TICKS - 5'h01 && $past(st_ff) == ST_CONV)
      else $error("conversion did not last twelve periods");
   a_wait_two: // see [RULE_15]
      assert property (st_ff == ST_WAIT && $past(st_ff) != ST_WAIT && on_ff |-> cnt_ff == 5'h00)
      else $error("wait counter not cleared on entry");
   a_wait_exit: // see [RULE_15] [RULE_25]
      assert property (on_ff && $past(on_ff) && st_ff == ST_IDLE && $past(st_ff) == ST_WAIT
                       |-> $past(cnt_ff) == WAIT_TICKS - 5'h01 && $past(tick))
      else $error("left wait before two periods");
   a_switch_open: // see [RULE_17]
      assert property (st_ff == ST_CONV |-> !sample_o)
      else $error("sampling switch closed during conversion");
   a_reserved_zero: // see [RULE_19]
      assert property (setup && hit(paddr_i, ADDR_TIMING) |=> prdata_o[6] == 1'b0 && prdata_o[31:8] == 24'h0)
      else $error("reserved bits read nonzero");
   a_left_justify: // see [RULE_06] [RULE_24]
      assert property (done && !just_ff |=> result_ff[5:0] == 6'h00 && result_ff[15:6] == $past(sar_ff))
      else $error("left justified result misplaced");
   a_right_justify: // see [RULE_06] [RULE_24]
      assert property (done && just_ff |=> result_ff[15:10] == 6'h00 && result_ff[9:0] == $past(sar_ff))
      else $error("right justified result misplaced");
   a_acq_zero: // see [RULE_23]
      assert property (st_ff == ST_IDLE && go_ff && on_ff && acq_len == 5'h00 && !wr |=> st_ff == ST_CONV)
      else $error("zero acquisition code did not convert at once");
   a_acq_count: // see [RULE_14] [RULE_07]
      assert property (st_ff == ST_CONV && $past(st_ff) == ST_ACQ && on_ff
                       |-> 5'($past(cnt_ff) + 5'h01) >= $past(acq_len) && $past(tick))
      else $error("acquisition ended early");
   a_abort_keeps: // see [RULE_22]
      assert property (st_ff == ST_CONV && !go_ff && on_ff && !done && !wr |=> $stable(result_ff))
      else $error("abort changed the result");
endmodule // sarseq_top

// >>> test/sarseq_afe_model.sv
module sarseq_afe_model (
   // clock
   input wire logic mclk_i,
   // converter side
   input wire logic [3:0] input_select_i,
   input wire logic sample_i,
   input wire logic [9:0] trial_code_i,
   // comparator
   output logic cmp_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] held_ff = 10'h000;
   // channel n carries level {n, 2B}; tracked while the switch is closed, held while it is open
   always_ff @(posedge mclk_i) begin
      if (sample_i) begin
         held_ff <= {input_select_i, 6'h2B};
      end
   end
   assign cmp_o = held_ff >= trial_code_i;
endmodule // sarseq_afe_model

// >>> test/sar_adc_sequencer_bench.sv
module sar_adc_sequencer_bench import sarseq_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic sleep_i = 1'b0;
   logic rc_clk_i = 1'b0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, converter_on_o, sample_o, cmp_i, flag_o, busy_o;
   logic [3:0] input_select_o;
   logic [1:0] reference_select_o;
   logic [15:0] pin_analog_config_o;
   logic [9:0] trial_code_o;
   int error_cnt = 0;
   int checks_done = 0;
   logic last_err;

   always #10 mclk_i = ~mclk_i;
   // free running rc oscillator, unrelated in phase
   always #73 rc_clk_i = ~rc_clk_i;

   sarseq_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sleep_i(sleep_i),
      .rc_clk_i(rc_clk_i), .converter_on_o(converter_on_o), .input_select_o(input_select_o),
      .reference_select_o(reference_select_o), .pin_analog_config_o(pin_analog_config_o),
      .sample_o(sample_o), .trial_code_o(trial_code_o), .cmp_i(cmp_i),
      .conversion_done_flag_o(flag_o), .busy_o(busy_o));
   sarseq_afe_model afe (.mclk_i(mclk_i), .input_select_i(input_select_o),
      .sample_i(sample_o), .trial_code_i(trial_code_o), .cmp_o(cmp_i));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready_o !== 1'b1);
      chk("wait_states", 1, n);
      q = prdata_o;
      last_err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      // outputs launched by this edge settle before callers look
      @(negedge mclk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask

   task automatic chk_res(input logic [3:0] ch, input logic j);
      logic [15:0] e;
      e = j ? {6'h00, ch, 6'h2B} : {ch, 6'h2B, 6'h00};
      rd(ADDR_RES_HI, {24'h0, e[15:8]}, "res_hi");
      rd(ADDR_RES_LO, {24'h0, e[7:0]}, "res_lo");
   endtask

   task automatic conv(input logic [3:0] ch, input logic [2:0] ck, input logic [2:0] aq,
                       input logic j, input logic vr, output int c);
      wr(ADDR_TIMING, {24'h0, j, 1'b0, aq, ck});
      wr(ADDR_CTRL, {26'h0, ch, 2'b01});
      wr(ADDR_STATUS, 32'h1);
      repeat (200) @(posedge mclk_i);
      wr(ADDR_CTRL, {26'h0, ch, 2'b11});
      @(negedge mclk_i);
      chk("sampling", {31'h0, aq != 3'h0}, {31'h0, sample_o});
      c = 1;
      while (busy_o === 1'b1 && c < 3000) begin
         @(negedge mclk_i);
         c++;
      end
      chk("flag", 1, {31'h0, flag_o});
      chk("busy", 0, {31'h0, busy_o});
      if (vr) chk_res(ch, j);
   endtask

   task automatic t_regs;
      rd(ADDR_CTRL, 0, "ctrl");
      rd(ADDR_PINREF, 0, "pinref");
      rd(ADDR_TIMING, 0, "timing");
      chk("pins", 32'hFFFF, {16'h0, pin_analog_config_o});
      wr(ADDR_CTRL, 32'hFF);
      rd(ADDR_CTRL, 32'h3D, "ctrl_ro");
      wr(ADDR_PINREF, 32'hFF);
      chk("pins_f", 32'h1, {16'h0, pin_analog_config_o});
      rd(ADDR_PINREF, 32'h3F, "pinref_ro");
      wr(ADDR_TIMING, 32'hFF);
      rd(ADDR_TIMING, 32'hBF, "timing_ro");
      rd(8'h3C, 0, "unmapped");
      chk("slverr", 1, {31'h0, last_err});
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_CTRL, {26'h0, i[3:0], 2'b01});
         chk("chan", i, {28'h0, input_select_o});
         if (i < 4) wr(ADDR_PINREF, {26'h0, i[1:0], 4'h0});
         if (i < 4) chk("ref", i, {30'h0, reference_select_o});
      end
      chk("pins_all", 32'hFFFF, {16'h0, pin_analog_config_o});
      $display("test regs done");
   endtask

   task automatic t_clocks;
      logic [2:0] cd[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
      int c, n;
      for (int i = 0; i < 6; i++) begin
         n = 2 << i;
         conv(4'hA, cd[i], 3'h0, 1'b1, i > 1, c);
         chk("conv_len", 1, {31'h0, c >= 11 * n && c <= 13 * n + 8});
      end
      wr(ADDR_STATUS, 32'h1);
      chk("flag_clr", 0, {31'h0, flag_o});
      $display("test clocks done");
   endtask

   task automatic t_acq;
      int tk[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
      int c;
      for (int i = 0; i < 8; i++) begin
         conv(i[3:0], 3'h1, i[2:0], i[0], 1'b1, c);
         chk("acq_len", 1, {31'h0, c >= (tk[i] + 11) * 8 && c <= (tk[i] + 13) * 8 + 8});
      end
      $display("test acquisition done");
   endtask

   task automatic t_abort;
      int c;
      wr(ADDR_RES_HI, 32'h01);
      wr(ADDR_RES_LO, 32'h5A);
      wr(ADDR_STATUS, 32'h1);
      wr(ADDR_TIMING, 32'h02);
      wr(ADDR_CTRL, {26'h0, 4'h5, 2'b11});
      repeat (100) @(posedge mclk_i);
      wr(ADDR_CTRL, {26'h0, 4'h5, 2'b01});
      @(negedge mclk_i);
      chk("abort_busy", 0, {31'h0, busy_o});
      chk("abort_flag", 0, {31'h0, flag_o});
      repeat (20) @(negedge mclk_i);
      chk("wait_samp", 0, {31'h0, sample_o});
      c = 0;
      while (sample_o !== 1'b1 && c < 200) begin
         @(negedge mclk_i);
         c++;
      end
      chk("resample", 1, {31'h0, sample_o});
      rd(ADDR_STATUS, 32'h4, "status");
      rd(ADDR_RES_HI, 32'h01, "abort_hi");
      rd(ADDR_RES_LO, 32'h5A, "abort_lo");
      $display("test abort done");
   endtask

   task automatic t_rc_sleep;
      int c;
      @(posedge mclk_i);
      sleep_i <= 1'b1;
      conv(4'h7, 3'h3, 3'h0, 1'b1, 1'b1, c);
      chk("rc_len", 1, {31'h0, c >= 4 && c <= 300});
      @(posedge mclk_i);
      sleep_i <= 1'b0;
      $display("test rc sleep done");
   endtask

   task automatic t_reset;
      wr(ADDR_TIMING, 32'h06);
      wr(ADDR_CTRL, 32'h03);
      wr(ADDR_CTRL, 32'h03);
      repeat (50) @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(negedge mclk_i);
      chk("rst_on", 0, {31'h0, converter_on_o});
      chk("rst_busy", 0, {31'h0, busy_o});
      rd(ADDR_CTRL, 0, "rst_ctrl");
      rd(ADDR_TIMING, 0, "rst_timing");
      chk_res(4'h7, 1'b1);
      $display("test reset done");
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #600000;
      error_cnt++;
      print_verdict();
   end

   initial begin
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_clocks();
      t_acq();
      t_abort();
      t_rc_sleep();
      t_reset();
      print_verdict();
   end
endmodule // sar_adc_sequencer_bench
